// *** hw/eag_top.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - stack relative adds signed byte displacement
// - stack relative only for move, no immediate
// - stack relative sum wraps in 16 bits
// - register relative displacements are unsigned
// - 20-bit absolute for far/jump/call only
// - register pairs for shifts and indirect jumps
// - control direct for control ops, stack select
// - address pair gives 20-bit far address
// - register plus 20-bit displacement, truncated
// - pc relative from instruction start
// - short jump lands two to nine ahead
// - byte jump signed 8-bit offset
// - word jump signed 16-bit offset
// - bit absolute counts from base bit 0
// - register bit position zero to fifteen
// - flag direct for flag ops, low byte
// - indirect bit count from address zero
// - relative bit count added to base
// - bit address wraps in 16 bits
// - static base plus unsigned base field
// - static field widths reach 32/256/8K bytes
// - frame base plus signed base field
// - bit count splits into byte and bit
// - generic: two-byte opcode, fields to three
// - quick: immediate in two-byte opcode
// - short: one-byte opcode, fields to two
// - zero: one-byte opcode, zero immediate
module eag_top
  import eag_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // decoded request
  input wire logic in_valid,
  input wire eag_mode_e mode,
  input wire eag_op_e op,
  input wire logic src_is_imm,
  input wire eag_len_e length_sel,
  input wire eag_fw_e field_width,
  input wire eag_pair_e pair_sel,
  input wire logic areg_sel,
  input wire eag_fmt_e fmt,
  // register values
  input wire logic [15:0] user_stack_ptr,
  input wire logic [15:0] interrupt_stack_ptr,
  input wire logic [15:0] flag_register,
  input wire logic [15:0] static_base_reg,
  input wire logic [15:0] frame_base_reg,
  input wire logic [15:0] addr_reg_zero,
  input wire logic [15:0] addr_reg_one,
  input wire logic [31:0] data_pair_low,
  input wire logic [31:0] data_pair_high,
  input wire logic [19:0] pc,
  // operand fields
  input wire logic [19:0] dsp,
  input wire logic [19:0] abs20,
  input wire logic [15:0] bit_num,
  input wire logic [15:0] base_field,
  // registered results
  output logic out_valid,
  output logic mode_legal,
  output logic [19:0] ea_out,
  output logic [2:0] bit_pos_out,
  output logic [3:0] reg_bit_out,
  output logic [31:0] pair_operand,
  output logic ctl_user_sp,
  output logic [1:0] opcode_bytes,
  output logic [1:0] src_field_max,
  output logic [1:0] dest_field_max,
  output logic imm_embedded,
  output logic imm_zero
);
  // whole state of the block
  typedef struct packed {
    logic valid;
    logic legal;
    logic [19:0] ea;
    logic [2:0] bit_pos;
    logic [3:0] reg_bit;
    logic [31:0] pair_val;
    logic user_sp;
    logic [1:0] opc;
    logic [1:0] src_max;
    logic [1:0] dst_max;
    logic imm_emb;
    logic imm_zero;
  } eag_state_s;

  eag_state_s st_reg; // registered state
  eag_state_s st_next; // next state

  logic [15:0] sel_sp; // stack pointer picked by the flag
  logic [15:0] areg; // chosen address register
  logic [31:0] addr_pair; // concatenated address registers
  logic [15:0] stat_mask; // static field width mask
  logic [15:0] areg_dsp; // unsigned near displacement
  logic [CNT_W-1:0] bit_count; // bit count fed to the splitter
  logic [15:0] bit_base; // byte base of a bit access
  logic [BYTE_W-1:0] byte_off; // byte part of the count
  logic [2:0] split_pos; // bit part of the count
  logic [15:0] byte_off16; // byte offset widened with sign
  logic [1:0] f_opc; // format table outputs
  logic [1:0] f_src;
  logic [1:0] f_dst;
  logic f_emb;
  logic f_zero;

  // stack select flag picks user or interrupt stack
  assign sel_sp = flag_register[STACK_SEL_BIT] ? user_stack_ptr
                                                    : interrupt_stack_ptr;
  assign areg = areg_sel ? addr_reg_one : addr_reg_zero;
  assign addr_pair = {addr_reg_one, addr_reg_zero};

  // width masks for the static base field
  assign stat_mask = (field_width == FW_8) ? STATIC_MASK_8 :
                     (field_width == FW_11) ? STATIC_MASK_11 : STATIC_MASK_16;
  // near displacement is zero extended, never sign extended
  assign areg_dsp = (field_width == FW_8) ? {8'h00, dsp[7:0]} : dsp[15:0];

  // bit count and byte base per bit mode
  always_comb begin
    bit_count = '0;
    bit_base = '0;
    unique case (mode)
      MODE_BIT_ABS: begin
        // count from bit 0 of the base address
        bit_count = {1'b0, bit_num};
        bit_base = base_field;
      end
      MODE_BIT_AIND: begin
        // register is a count from address zero
        bit_count = {1'b0, areg};
      end
      MODE_BIT_AREL: begin
        // register is a count above the base
        bit_count = {1'b0, areg};
        bit_base = areg_dsp;
      end
      MODE_BIT_SBREL: begin
        // unsigned field added to static base
        bit_count = {1'b0, base_field & stat_mask};
        bit_base = static_base_reg;
      end
      MODE_BIT_FBREL: begin
        // signed field added to frame base
        bit_count = {{9{base_field[7]}}, base_field[7:0]};
        bit_base = frame_base_reg;
      end
      default: begin
        bit_count = '0;
        bit_base = '0;
      end
    endcase
  end

  // shift the count into bytes and bit position
  eag_bit_split #(.N(CNT_W)) u_split (
    .bit_count(bit_count),
    .byte_off(byte_off),
    .bit_pos(split_pos)
  );

  // field sizes for the opcode format
  eag_fmt_len u_fmt (
    .fmt(fmt),
    .opc_bytes(f_opc),
    .src_max(f_src),
    .dst_max(f_dst),
    .imm_embedded(f_emb),
    .imm_zero(f_zero)
  );

  // negative frame counts keep their sign in the byte part
  assign byte_off16 = {{(16 - BYTE_W){byte_off[BYTE_W-1]}}, byte_off};

  // next state from mode fields and register values
  always_comb begin
    st_next = '0;
    st_next.valid = in_valid;
    st_next.legal = 1'b1;
    st_next.opc = f_opc;
    st_next.src_max = f_src;
    st_next.dst_max = f_dst;
    st_next.imm_emb = f_emb;
    st_next.imm_zero = f_zero;
    unique case (mode)
      MODE_SP_REL: begin
        // signed byte displacement, carry beyond 16 bits dropped
        st_next.ea = {4'h0, 16'(sel_sp + {{8{dsp[7]}}, dsp[7:0]})};
        st_next.legal = (op == OP_MOVE) && !src_is_imm;
      end
      MODE_AREG_REL: begin
        // unsigned displacement on an address register
        st_next.ea = {4'h0, 16'(areg + areg_dsp)};
      end
      MODE_ABS20: begin
        // used as is
        st_next.ea = abs20;
        st_next.legal = (op == OP_FAR_LOAD) || (op == OP_FAR_STORE) ||
                        (op == OP_JUMP) || (op == OP_CALL);
      end
      MODE_PAIR_DIRECT: begin
        // 32-bit operand from a register pair
        unique case (pair_sel)
          PAIR_DATA_LOW: st_next.pair_val = data_pair_low;
          PAIR_DATA_HIGH: st_next.pair_val = data_pair_high;
          PAIR_ADDR: st_next.pair_val = addr_pair;
          default: st_next.pair_val = '0;
        endcase
        st_next.ea = st_next.pair_val[ADDR_W-1:0];
        if (op == OP_IND_JUMP || op == OP_IND_CALL) begin
          st_next.legal = (pair_sel != 2'h3);
        end else begin
          // shifts take only the data pairs
          st_next.legal = ((op == OP_LOGICAL_SHIFT) || (op == OP_ARITH_SHIFT)) &&
                          (pair_sel != PAIR_ADDR) && (pair_sel != 2'h3);
        end
      end
      MODE_PAIR_IND: begin
        // bits from 20 upward ignored
        st_next.ea = addr_pair[ADDR_W-1:0];
        st_next.legal = (op == OP_FAR_LOAD) || (op == OP_FAR_STORE);
      end
      MODE_DSP20: begin
        // 20-bit sum with overflow dropped
        st_next.ea = 20'({4'h0, areg} + dsp);
        st_next.legal = (op == OP_FAR_LOAD) || (op == OP_FAR_STORE) ||
                        (op == OP_IND_JUMP) || (op == OP_IND_CALL);
      end
      MODE_CTL_DIRECT: begin
        // stack pointer resolved by the stack select flag
        st_next.user_sp = flag_register[STACK_SEL_BIT];
        st_next.ea = {4'h0, sel_sp};
        st_next.legal = (op == OP_CTL_LOAD) || (op == OP_CTL_STORE) ||
                        (op == OP_CTL_PUSH) || (op == OP_CTL_POP);
      end
      MODE_PC_REL: begin
        // offset taken from the jump instruction start
        unique case (length_sel)
          LEN_SHORT: st_next.ea = 20'(pc + PC_SHORT_BIAS + {17'h0_0000, dsp[2:0]});
          LEN_BYTE: st_next.ea = 20'(pc + {{12{dsp[7]}}, dsp[7:0]});
          LEN_WORD: st_next.ea = 20'(pc + {{4{dsp[15]}}, dsp[15:0]});
          default: st_next.legal = 1'b0;
        endcase
        if ((op != OP_JUMP) && (op != OP_CALL)) begin
          st_next.legal = 1'b0;
        end
      end
      MODE_BIT_REG: begin
        // one bit of a 16-bit register
        st_next.reg_bit = bit_num[3:0];
      end
      MODE_BIT_FLAG: begin
        // only the low byte of the flag register
        st_next.reg_bit = {1'b0, bit_num[2:0]};
        st_next.legal = ((op == OP_FLAG_CLEAR) || (op == OP_FLAG_SET)) &&
                        (bit_num[15:3] == 13'h0000);
      end
      default: begin
        // memory bit modes, address wraps in 16 bits
        st_next.ea = {4'h0, 16'(bit_base + byte_off16)};
        st_next.bit_pos = split_pos;
      end
    endcase
  end

  // single register stage for the access stage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state
  assign out_valid = st_reg.valid;
  assign mode_legal = st_reg.legal;
  assign ea_out = st_reg.ea;
  assign bit_pos_out = st_reg.bit_pos;
  assign reg_bit_out = st_reg.reg_bit;
  assign pair_operand = st_reg.pair_val;
  assign ctl_user_sp = st_reg.user_sp;
  assign opcode_bytes = st_reg.opc;
  assign src_field_max = st_reg.src_max;
  assign dest_field_max = st_reg.dst_max;
  assign imm_embedded = st_reg.imm_emb;
  assign imm_zero = st_reg.imm_zero;

  // checks of the address arithmetic, mode gating and valid timing
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sp_rel_sum_a: assert property (
    (mode == MODE_SP_REL) |=>
      ea_out == {4'h0, 16'($past(sel_sp) + {{8{$past(dsp[7])}}, $past(dsp[7:0])})})
    else $error("stack relative address wrong");

  sp_rel_gate_a: assert property (
    (mode == MODE_SP_REL && (src_is_imm || op != OP_MOVE)) |=> !mode_legal)
    else $error("stack relative accepted illegally");

  near_wrap_a: assert property (
    ($past(mode) == MODE_SP_REL || $past(mode) == MODE_BIT_ABS) |-> ea_out[19:16] == 4'h0)
    else $error("near address above 16 bits");

  abs20_use_a: assert property (
    (mode == MODE_ABS20 && op == OP_JUMP) |=> ea_out == $past(abs20) && mode_legal)
    else $error("absolute address not passed");

  pair_far_a: assert property (
    (mode == MODE_PAIR_IND) |=> ea_out == $past(addr_pair[19:0]))
    else $error("pair indirect address wrong");

  dsp20_sum_a: assert property (
    (mode == MODE_DSP20 && !areg_sel) |=>
      ea_out == 20'({4'h0, $past(addr_reg_zero)} + $past(dsp)))
    else $error("20-bit displacement sum wrong");

  short_jump_a: assert property (
    (mode == MODE_PC_REL && length_sel == LEN_SHORT) |=>
      (20'(ea_out - $past(pc)) >= 20'h0_0002) && (20'(ea_out - $past(pc)) <= 20'h0_0009))
    else $error("short jump out of range");

  byte_jump_a: assert property (
    (mode == MODE_PC_REL && length_sel == LEN_BYTE) |=>
      ea_out == 20'($past(pc) + {{12{$past(dsp[7])}}, $past(dsp[7:0])}))
    else $error("byte jump target wrong");

  bit_abs_pos_a: assert property (
    (mode == MODE_BIT_ABS) |=> bit_pos_out == $past(bit_num[2:0]) &&
      ea_out[15:0] == 16'($past(base_field) + {3'h0, $past(bit_num[15:3])}))
    else $error("bit absolute location wrong");

  frame_bit_a: assert property (
    (mode == MODE_BIT_FBREL && base_field[7]) |=>
      ea_out[15:0] != $past(frame_base_reg) || $past(base_field[7:0]) == 8'h00)
    else $error("frame bit offset not negative");

  flag_gate_a: assert property (
    (mode == MODE_BIT_FLAG && op != OP_FLAG_SET && op != OP_FLAG_CLEAR) |=> !mode_legal)
    else $error("flag direct accepted illegally");

  reg_stage_a: assert property (
    out_valid == $past(in_valid))
    else $error("valid not one cycle late");

  // main scenarios
  cov_sp_neg: cover property (mode == MODE_SP_REL && dsp[7] ##1 mode_legal);
  cov_bit_static: cover property (mode == MODE_BIT_SBREL && field_width == FW_11);
  cov_word_jump: cover property (mode == MODE_PC_REL && length_sel == LEN_WORD);
  cov_pair_shift: cover property (mode == MODE_PAIR_DIRECT && op == OP_LOGICAL_SHIFT);
endmodule

// *** hw/eag_pkg.sv ***
package eag_pkg;
  // address widths
  localparam int ADDR_W = 20;
  localparam int NEAR_W = 16;
  localparam int CNT_W = 17;
  localparam int BYTE_W = CNT_W - 3;
  // flag bit that picks the user stack pointer
  localparam int STACK_SEL_BIT = 7;
  // short jump distance is biased by two
  localparam logic [19:0] PC_SHORT_BIAS = 20'h0_0002;
  // static-base field width masks
  localparam logic [15:0] STATIC_MASK_8 = 16'h00ff;
  localparam logic [15:0] STATIC_MASK_11 = 16'h07ff;
  localparam logic [15:0] STATIC_MASK_16 = 16'hffff;
  // format field sizes in bytes
  localparam logic [1:0] OPC_ONE = 2'h1;
  localparam logic [1:0] OPC_TWO = 2'h2;
  localparam logic [1:0] FLD_TWO = 2'h2;
  localparam logic [1:0] FLD_THREE = 2'h3;

  // addressing modes handed over by the decoder
  typedef enum logic [3:0] {
    MODE_SP_REL, MODE_AREG_REL, MODE_ABS20, MODE_PAIR_DIRECT, MODE_PAIR_IND,
    MODE_DSP20, MODE_CTL_DIRECT, MODE_PC_REL, MODE_BIT_ABS, MODE_BIT_REG,
    MODE_BIT_FLAG, MODE_BIT_AIND, MODE_BIT_AREL, MODE_BIT_SBREL, MODE_BIT_FBREL
  } eag_mode_e;

  // operation classes that gate the modes
  typedef enum logic [3:0] {
    OP_MOVE, OP_FAR_LOAD, OP_FAR_STORE, OP_JUMP, OP_CALL, OP_IND_JUMP,
    OP_IND_CALL, OP_LOGICAL_SHIFT, OP_ARITH_SHIFT, OP_CTL_LOAD, OP_CTL_STORE,
    OP_CTL_PUSH, OP_CTL_POP, OP_FLAG_CLEAR, OP_FLAG_SET, OP_OTHER
  } eag_op_e;

  // jump distance specifier
  typedef enum logic [1:0] {LEN_SHORT, LEN_BYTE, LEN_WORD} eag_len_e;
  // displacement or base field width
  typedef enum logic [1:0] {FW_8, FW_11, FW_16} eag_fw_e;
  // 32-bit register pair
  typedef enum logic [1:0] {PAIR_DATA_LOW, PAIR_DATA_HIGH, PAIR_ADDR} eag_pair_e;
  // opcode format
  typedef enum logic [1:0] {FMT_GENERIC, FMT_QUICK, FMT_SHORT, FMT_ZERO} eag_fmt_e;
endpackage

// *** hw/eag_bit_split.sv ***
`timescale 1ns/1ps
// splits a bit count into a byte offset and a bit position
module eag_bit_split
  import eag_pkg::*;
#(
  parameter int N = 17
) (
  // bit count in
  input wire logic [N-1:0] bit_count,
  // byte offset and position out
  output logic [N-4:0] byte_off,
  output logic [2:0] bit_pos
);
  // shift right three places, low three bits are the position
  assign byte_off = bit_count[N-1:3];
  assign bit_pos = bit_count[2:0];
endmodule

// *** hw/eag_fmt_len.sv ***
`timescale 1ns/1ps
// field sizes per opcode format
module eag_fmt_len
  import eag_pkg::*;
(
  // chosen format
  input wire eag_fmt_e fmt,
  // sizes in bytes
  output logic [1:0] opc_bytes,
  output logic [1:0] src_max,
  output logic [1:0] dst_max,
  // immediate kind
  output logic imm_embedded,
  output logic imm_zero
);
  // one combinational table
  always_comb begin
    opc_bytes = OPC_TWO;
    src_max = FLD_THREE;
    dst_max = FLD_THREE;
    imm_embedded = 1'b0;
    imm_zero = 1'b0;
    unique case (fmt)
      FMT_GENERIC: begin
        // two-byte opcode, fields up to three bytes
        opc_bytes = OPC_TWO;
      end
      FMT_QUICK: begin
        // small immediate inside the opcode
        src_max = 2'h0;
        dst_max = FLD_TWO;
        imm_embedded = 1'b1;
      end
      FMT_SHORT: begin
        // one-byte opcode, fields up to two bytes
        opc_bytes = OPC_ONE;
        src_max = FLD_TWO;
        dst_max = FLD_TWO;
      end
      FMT_ZERO: begin
        // implied immediate of zero
        opc_bytes = OPC_ONE;
        src_max = 2'h0;
        dst_max = FLD_TWO;
        imm_embedded = 1'b1;
        imm_zero = 1'b1;
      end
    endcase
  end
endmodule

// *** tb/eag_mem_model.sv ***
`timescale 1ns/1ps
// memory-bus side: latches each legal address that the block presents
module eag_mem_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // address stage outputs of the block
  input wire logic out_valid,
  input wire logic mode_legal,
  input wire logic [19:0] ea_out,
  // last address taken by the bus
  output logic [19:0] last_addr
);
  // capture on the edge after the address appears; illegal modes never reach the bus
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_addr <= 20'h0_0000;
    end else if (out_valid && mode_legal) begin
      last_addr <= ea_out;
    end
  end
endmodule

// *** tb/effective_address_generator_tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module effective_address_generator_tb import eag_pkg::*;;
  // stimulus
  logic clk = 1'b0;
  logic rstn, in_valid, src_is_imm, areg_sel;
  eag_mode_e mode;
  eag_op_e op;
  eag_len_e length_sel;
  eag_fw_e field_width;
  eag_pair_e pair_sel;
  eag_fmt_e fmt;
  logic [15:0] user_stack_ptr, interrupt_stack_ptr, flag_register, static_base_reg;
  logic [15:0] frame_base_reg, addr_reg_zero, addr_reg_one, bit_num, base_field;
  logic [31:0] data_pair_low, data_pair_high;
  logic [19:0] pc, dsp, abs20;
  // results
  logic out_valid, mode_legal, ctl_user_sp, imm_embedded, imm_zero;
  logic [19:0] ea_out, last_addr;
  logic [2:0] bit_pos_out;
  logic [3:0] reg_bit_out;
  logic [31:0] pair_operand;
  logic [1:0] opcode_bytes, src_field_max, dest_field_max;
  int n_tests = 0;
  int n_mismatch = 0;

  // 200 MHz clock
  always #2.5 clk = ~clk;

  eag_top uut (.clk, .rstn, .in_valid, .mode, .op, .src_is_imm, .length_sel, .field_width,
    .pair_sel, .areg_sel, .fmt, .user_stack_ptr, .interrupt_stack_ptr, .flag_register,
    .static_base_reg, .frame_base_reg, .addr_reg_zero, .addr_reg_one, .data_pair_low,
    .data_pair_high, .pc, .dsp, .abs20, .bit_num, .base_field, .out_valid, .mode_legal,
    .ea_out, .bit_pos_out, .reg_bit_out, .pair_operand, .ctl_user_sp, .opcode_bytes,
    .src_field_max, .dest_field_max, .imm_embedded, .imm_zero);

  eag_mem_model mem (.clk, .rstn, .out_valid, .mode_legal, .ea_out, .last_addr);

  // one edge passes; inputs change and results are looked at 1 ns after it
  task step;
    @(posedge clk);
    #1;
  endtask

  // verdict and end of run
  task complete_run;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // stack relative: signed byte offset, 16-bit wrap, move only
  task t_sp_rel;
    mode = MODE_SP_REL; op = OP_MOVE; src_is_imm = 1'b0; flag_register = 16'h0080;
    user_stack_ptr = 16'h1000; interrupt_stack_ptr = 16'h0050; dsp = 20'h0_00FB;
    step; `CHK(ea_out, 20'h0_0FFB)
    `CHK(mode_legal, 1'b1)
    user_stack_ptr = 16'hFFF0; dsp = 20'hF_FF7F;
    step; `CHK(ea_out, 20'h0_006F)
    flag_register = 16'h0000; dsp = 20'h0_0080;
    step; `CHK(ea_out, 20'h0_FFD0)
    src_is_imm = 1'b1;
    step; `CHK(mode_legal, 1'b0)
    src_is_imm = 1'b0; op = OP_JUMP;
    step; `CHK(mode_legal, 1'b0)
    $display("test sp_rel done");
  endtask

  // register relative: displacement taken without sign
  task t_areg;
    mode = MODE_AREG_REL; op = OP_MOVE; areg_sel = 1'b1; addr_reg_one = 16'hFF00;
    field_width = FW_8; dsp = 20'hF_FFFF;
    step; `CHK(ea_out, 20'h0_FFFF)
    field_width = FW_16; addr_reg_one = 16'h0002;
    step; `CHK(ea_out, 20'h0_0001)
    areg_sel = 1'b0; addr_reg_zero = 16'h0100; field_width = FW_8; dsp = 20'h0_0080;
    step; `CHK(ea_out, 20'h0_0180)
    $display("test areg_rel done");
  endtask

  // 20-bit absolute, register pairs, pair indirect, 20-bit displacement
  task t_special;
    mode = MODE_ABS20; abs20 = 20'hA_BCDE;
    for (int i = 1; i <= 4; i++) begin
      op = eag_op_e'(i);
      step; `CHK(ea_out, 20'hA_BCDE)
      `CHK(mode_legal, 1'b1)
    end
    op = OP_MOVE;
    step; `CHK(mode_legal, 1'b0)
    mode = MODE_PAIR_DIRECT; op = OP_LOGICAL_SHIFT; pair_sel = PAIR_DATA_LOW;
    data_pair_low = 32'h1234_5678; data_pair_high = 32'h9ABC_DEF0;
    addr_reg_one = 16'h0002; addr_reg_zero = 16'h0000;
    step; `CHK(pair_operand, 32'h1234_5678)
    `CHK(mode_legal, 1'b1)
    op = OP_ARITH_SHIFT; pair_sel = PAIR_DATA_HIGH;
    step; `CHK(pair_operand, 32'h9ABC_DEF0)
    pair_sel = PAIR_ADDR;
    step; `CHK(mode_legal, 1'b0)
    op = OP_IND_JUMP;
    step; `CHK(mode_legal, 1'b1)
    `CHK(ea_out, 20'h2_0000)
    pair_sel = eag_pair_e'(2'h3);
    step; `CHK(mode_legal, 1'b0)
    `CHK(pair_operand, 32'h0000_0000)
    mode = MODE_PAIR_IND; op = OP_FAR_STORE; addr_reg_one = 16'hFFFF; addr_reg_zero = 16'h1234;
    step; `CHK(ea_out, 20'hF_1234)
    `CHK(mode_legal, 1'b1)
    op = OP_JUMP;
    step; `CHK(mode_legal, 1'b0)
    mode = MODE_DSP20; op = OP_IND_CALL; areg_sel = 1'b0; addr_reg_zero = 16'hFFFF;
    dsp = 20'hF_FFFF;
    step; `CHK(ea_out, 20'h0_FFFE)
    `CHK(mode_legal, 1'b1)
    op = OP_MOVE;
    step; `CHK(mode_legal, 1'b0)
    $display("test special done");
  endtask

  // control register direct: the four control ops, stack select flag
  task t_ctl;
    mode = MODE_CTL_DIRECT; flag_register = 16'h0080;
    user_stack_ptr = 16'h1000; interrupt_stack_ptr = 16'h0050;
    for (int i = 9; i <= 12; i++) begin
      op = eag_op_e'(i);
      step; `CHK(mode_legal, 1'b1)
      `CHK(ctl_user_sp, 1'b1)
      `CHK(ea_out, 20'h0_1000)
    end
    flag_register = 16'h0000;
    step; `CHK(ctl_user_sp, 1'b0)
    `CHK(ea_out, 20'h0_0050)
    op = OP_MOVE;
    step; `CHK(mode_legal, 1'b0)
    $display("test ctl_direct done");
  endtask

  // one pc relative target
  task pc_case(input eag_len_e l, input logic [19:0] d, input logic [19:0] e);
    length_sel = l;
    dsp = d;
    step; `CHK(ea_out, e)
  endtask

  // pc relative from the instruction start, all three distances at their limits
  task t_pc;
    mode = MODE_PC_REL; op = OP_JUMP; pc = 20'h1_0000;
    pc_case(LEN_SHORT, 20'h0_0000, 20'h1_0002);
    pc_case(LEN_SHORT, 20'hF_FFF7, 20'h1_0009);
    pc_case(LEN_BYTE, 20'h0_0080, 20'h0_FF80);
    pc_case(LEN_BYTE, 20'h0_007F, 20'h1_007F);
    pc_case(LEN_WORD, 20'h0_8000, 20'h0_8000);
    op = OP_CALL;
    pc_case(LEN_WORD, 20'h0_7FFF, 20'h1_7FFF);
    `CHK(mode_legal, 1'b1)
    op = OP_MOVE;
    step; `CHK(mode_legal, 1'b0)
    $display("test pc_rel done");
  endtask

  // one memory bit address and position
  task bit_case(input eag_mode_e m, input logic [19:0] e, input logic [2:0] p);
    mode = m;
    step; `CHK(ea_out, e)
    `CHK(bit_pos_out, p)
  endtask

  // bit modes: count split into bytes and bit, bases, wrap, register and flag bits
  task t_bits;
    op = OP_OTHER; bit_num = 16'h1234; base_field = 16'h0100;
    bit_case(MODE_BIT_ABS, 20'h0_0346, 3'h4);
    areg_sel = 1'b0; addr_reg_zero = 16'hFFFF;
    bit_case(MODE_BIT_AIND, 20'h0_1FFF, 3'h7);
    addr_reg_zero = 16'h0010; field_width = FW_16; dsp = 20'h0_FFFF;
    bit_case(MODE_BIT_AREL, 20'h0_0001, 3'h0);
    field_width = FW_8; dsp = 20'h0_0105;
    bit_case(MODE_BIT_AREL, 20'h0_0007, 3'h0);
    static_base_reg = 16'h2000; base_field = 16'hFFFF;
    bit_case(MODE_BIT_SBREL, 20'h0_201F, 3'h7);
    field_width = FW_11;
    bit_case(MODE_BIT_SBREL, 20'h0_20FF, 3'h7);
    field_width = FW_16;
    bit_case(MODE_BIT_SBREL, 20'h0_3FFF, 3'h7);
    static_base_reg = 16'hFFF0;
    bit_case(MODE_BIT_SBREL, 20'h0_1FEF, 3'h7);
    frame_base_reg = 16'h0100; base_field = 16'hFF80;
    bit_case(MODE_BIT_FBREL, 20'h0_00F0, 3'h0);
    base_field = 16'h007F;
    bit_case(MODE_BIT_FBREL, 20'h0_010F, 3'h7);
    mode = MODE_BIT_REG; bit_num = 16'h001F;
    step; `CHK(reg_bit_out, 4'hF)
    mode = MODE_BIT_FLAG; op = OP_FLAG_SET; bit_num = 16'h0007;
    step; `CHK(mode_legal, 1'b1)
    `CHK(reg_bit_out, 4'h7)
    bit_num = 16'h0008;
    step; `CHK(mode_legal, 1'b0)
    op = OP_FLAG_CLEAR; bit_num = 16'h0000;
    step; `CHK(mode_legal, 1'b1)
    op = OP_MOVE;
    step; `CHK(mode_legal, 1'b0)
    $display("test bit_modes done");
  endtask

  // the four opcode formats and their field sizes
  task t_fmt;
    logic [7:0] e_opc, e_src, e_dst;
    logic [3:0] e_emb, e_zero;
    e_opc = {2'h1, 2'h1, 2'h2, 2'h2};
    e_src = {2'h0, 2'h2, 2'h0, 2'h3};
    e_dst = {2'h2, 2'h2, 2'h2, 2'h3};
    e_emb = 4'b1010;
    e_zero = 4'b1000;
    for (int i = 0; i < 4; i++) begin
      fmt = eag_fmt_e'(i);
      step; `CHK(opcode_bytes, e_opc[2*i +: 2])
      `CHK(src_field_max, e_src[2*i +: 2])
      `CHK(dest_field_max, e_dst[2*i +: 2])
      `CHK(imm_embedded, e_emb[i])
      `CHK(imm_zero, e_zero[i])
    end
    $display("test formats done");
  endtask

  // a request then an idle cycle, bus capture, reset in mid-run
  task t_pipe;
    mode = MODE_ABS20; op = OP_FAR_LOAD; in_valid = 1'b1; abs20 = 20'h1_2345;
    step; `CHK(out_valid, 1'b1)
    `CHK(ea_out, 20'h1_2345)
    in_valid = 1'b0; abs20 = 20'h5_4321;
    step; `CHK(out_valid, 1'b0)
    `CHK(ea_out, 20'h5_4321)
    `CHK(last_addr, 20'h1_2345)
    rstn = 1'b0;
    #1; `CHK(ea_out, 20'h0_0000)
    step; rstn = 1'b1;
    $display("test pipeline done");
  endtask

  // reset, then every scenario in turn
  initial begin
    rstn = 1'b0; in_valid = 1'b0; mode = MODE_SP_REL; op = OP_MOVE; src_is_imm = 1'b0;
    length_sel = LEN_SHORT; field_width = FW_8; pair_sel = PAIR_DATA_LOW; areg_sel = 1'b0;
    fmt = FMT_GENERIC; user_stack_ptr = 16'h0000; interrupt_stack_ptr = 16'h0000;
    flag_register = 16'h0000; static_base_reg = 16'h0000; frame_base_reg = 16'h0000;
    addr_reg_zero = 16'h0000; addr_reg_one = 16'h0000; data_pair_low = 32'h0000_0000;
    data_pair_high = 32'h0000_0000; pc = 20'h0_0000; dsp = 20'h0_0000; abs20 = 20'h0_0000;
    bit_num = 16'h0000; base_field = 16'h0000;
    repeat (5) @(posedge clk);
    #1; `CHK(out_valid, 1'b0)
    rstn = 1'b1; in_valid = 1'b1;
    t_sp_rel;
    t_areg;
    t_special;
    t_ctl;
    t_pc;
    t_bits;
    t_fmt;
    t_pipe;
    complete_run;
  end

  // hang guard
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end
endmodule
